//--- pouc_map.vh
// Register map, field layout, codes and timing constants of the teleprotection logic
`ifndef POUC_MAP_VH
`define POUC_MAP_VH

// ************************************************************
// Register word addresses (byte address / 4)
// ************************************************************
`define POUC_ADDR_W 3
`define POUC_A_CTRL 3'h0
`define POUC_A_CMIN 3'h1
`define POUC_A_STAT 3'h2
`define POUC_A_ISTS 3'h3
`define POUC_A_IMSK 3'h4

// ************************************************************
// Control word fields
// ************************************************************
`define POUC_F_SCH_LO 0
`define POUC_F_SCH_HI 1
`define POUC_F_WI_LO 2
`define POUC_F_WI_HI 3
`define POUC_F_OBTX 4
`define POUC_CTRL_W 5
`define POUC_STAT_W 4
`define POUC_CTRL_RST 5'h00

// ************************************************************
// Scheme and weak infeed mode codes
// ************************************************************
`define POUC_SCH_NONE 2'h0
`define POUC_SCH_POTT 2'h1
`define POUC_SCH_UNBL 2'h2
`define POUC_WI_OFF 2'h0
`define POUC_WI_ECHO 2'h1
`define POUC_WI_ECTR 2'h2

// ************************************************************
// Event bits (status and interrupt words)
// ************************************************************
`define POUC_EV_TRIP 0
`define POUC_EV_TX 1
`define POUC_EV_FAIL 2
`define POUC_EV_W 3

// ************************************************************
// Times in milliseconds and clock rate
// ************************************************************
`define POUC_CLK_HZ 25000000
`define POUC_MS_PER_S 1000
`define POUC_BRK_TX_MS 8'h64
`define POUC_FSW_MS 8'h0a
`define POUC_WIN_MS 8'h96
`define POUC_FAIL_MS 8'hc8
`define POUC_CMIN_RST 16'h0000

`endif

//--- pouc_top.v
// Permissive overreach and unblocking teleprotection logic with Avalon-MM registers
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`include "pouc_map.vh"

module pouc_top #(
  parameter TICK_CYC = `POUC_CLK_HZ / `POUC_MS_PER_S, // Clock cycles per millisecond
  parameter CMIN_W = 16 // Width of carrier minimum time setting
) (
  // Clock and reset
  input wire mclk_i,
  input wire srst_i,
  // Avalon-MM slave
  input wire [`POUC_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Protection element inputs
  input wire underreach_pickup_i,
  input wire overreach_pickup_i,
  input wire reverse_current_block_i,
  input wire weak_infeed_echo_i,
  input wire weak_infeed_trip_i,
  input wire breaker_open_i,
  input wire channel_trip_block_in_i,
  // Carrier equipment contacts
  input wire channel_receive_in_i,
  input wire guard_loss_in_i,
  // Scheme outputs
  output reg channel_transmit_o,
  output reg scheme_trip_o,
  output reg carrier_equipment_fail_o,
  output reg irq_o
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Saturating millisecond counter step
  function [7:0] ms_step;
    input [7:0] cnt;
    input run;
    input tick;
    input [7:0] lim;
    begin
      if (!run) begin
        ms_step = 8'h00;
      end else if (tick && cnt != lim) begin
        ms_step = cnt + 8'h01;
      end else begin
        ms_step = cnt;
      end
    end
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  reg [`POUC_CTRL_W-1:0] ctrl_q; // Scheme, weak infeed mode, open breaker enable
  reg [CMIN_W-1:0] cmin_q; // Carrier minimum time in ms
  reg [`POUC_EV_W-1:0] ists_q; // Sticky event bits
  reg [`POUC_EV_W-1:0] imsk_q; // Interrupt mask
  reg [31:0] tick_cnt_q; // Millisecond prescaler
  reg tick_q; // One-cycle millisecond tick
  reg [7:0] brk_cnt_q; // Breaker-open delay timer
  reg [7:0] gl_cnt_q; // Guard loss persistence timer
  reg [7:0] win_cnt_q; // Unblock window remaining
  reg [7:0] fl_cnt_q; // Reception-without-guard-loss timer
  reg [CMIN_W-1:0] hold_cnt_q; // Transmit hold remaining
  reg tx_prev_q; // Transmit level last cycle, for edge
  reg trip_prev_q; // Trip level last cycle, for edge
  reg fail_prev_q; // Fail level last cycle, for edge
  reg [31:0] rdata_d; // Read mux
  wire [1:0] sch = ctrl_q[`POUC_F_SCH_HI:`POUC_F_SCH_LO];
  wire [1:0] wim = ctrl_q[`POUC_F_WI_HI:`POUC_F_WI_LO];
  wire obtx_en = ctrl_q[`POUC_F_OBTX];
  wire bus_req = avs_read_i | avs_write_i;
  wire acc = bus_req & ~avs_waitrequest_o; // Access completes this edge
  wire wr_acc = acc & avs_write_i;
  wire pott = (sch == `POUC_SCH_POTT);
  wire unbl = (sch == `POUC_SCH_UNBL);
  wire sch_on = pott | unbl;
  wire echo_en = (wim == `POUC_WI_ECHO) | (wim == `POUC_WI_ECTR);
  wire wtrip_en = (wim == `POUC_WI_ECTR);
  wire ovr = overreach_pickup_i & ~reverse_current_block_i;
  wire blk = channel_trip_block_in_i;
  wire rx = channel_receive_in_i;
  wire gl = guard_loss_in_i;
  wire brk_run = sch_on & obtx_en & breaker_open_i;
  wire brk_tx = (brk_cnt_q == `POUC_BRK_TX_MS);
  wire gl_alone = unbl & gl & ~rx;
  wire win_open = (win_cnt_q != 8'h00);
  wire fail_now = (fl_cnt_q == `POUC_FAIL_MS);
  wire tx_req;
  wire tx_now;
  wire trip_now;
  wire [`POUC_EV_W-1:0] ev_set;

  // ************************************************************
  // Millisecond tick
  // ************************************************************

  // Prescaler: one tick every TICK_CYC clocks
  always @(posedge mclk_i) begin
    if (srst_i) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYC - 1) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // ************************************************************
  // Scheme timers
  // ************************************************************

  // Delay timers restart when their condition drops, the window only when unblocking is deselected;
  // first ms may be partial since ticks run free
  always @(posedge mclk_i) begin
    if (srst_i) begin
      brk_cnt_q <= 8'h00;
      gl_cnt_q <= 8'h00;
      win_cnt_q <= 8'h00;
      fl_cnt_q <= 8'h00;
    end else begin
      // Open-breaker transmit in both schemes after 100 ms
      brk_cnt_q <= ms_step(brk_cnt_q, brk_run, tick_q, `POUC_BRK_TX_MS);
      gl_cnt_q <= ms_step(gl_cnt_q, gl_alone, tick_q, `POUC_FSW_MS);
      fl_cnt_q <= ms_step(fl_cnt_q, unbl & rx & ~gl, tick_q, `POUC_FAIL_MS);
      // Window opens once per guard-loss episode
      if (!unbl) begin
        win_cnt_q <= 8'h00;
      end else if (gl_alone && tick_q && gl_cnt_q == `POUC_FSW_MS - 8'h01) begin
        win_cnt_q <= `POUC_WIN_MS;
      end else if (tick_q && win_open) begin
        win_cnt_q <= win_cnt_q - 8'h01;
      end
    end
  end

  // ************************************************************
  // Transmit and trip decisions
  // ************************************************************

  // Transmit request: pickup, delayed breaker open, echo
  assign tx_req = sch_on & (underreach_pickup_i | ovr | brk_tx
                  | (weak_infeed_echo_i & echo_en));

  // Request or minimum-time hold, blocked by trip block
  assign tx_now = (tx_req | (hold_cnt_q != {CMIN_W{1'b0}})) & ~blk;

  // Scheme trip per selected scheme
  assign trip_now = ~blk & (
    (pott & rx & ovr)
    | (unbl & rx & gl & ovr)
    | (unbl & win_open & ovr)
    | (sch_on & weak_infeed_trip_i & wtrip_en));

  // Hold timer reloads while request stands, then counts down
  always @(posedge mclk_i) begin
    if (srst_i) begin
      hold_cnt_q <= {CMIN_W{1'b0}};
    end else if (tx_req) begin
      hold_cnt_q <= cmin_q;
    end else if (tick_q && hold_cnt_q != {CMIN_W{1'b0}}) begin
      hold_cnt_q <= hold_cnt_q - {{(CMIN_W-1){1'b0}}, 1'b1};
    end
  end

  // Registered scheme outputs
  always @(posedge mclk_i) begin
    if (srst_i) begin
      channel_transmit_o <= 1'b0;
      scheme_trip_o <= 1'b0;
      carrier_equipment_fail_o <= 1'b0;
    end else begin
      channel_transmit_o <= tx_now;
      scheme_trip_o <= trip_now;
      carrier_equipment_fail_o <= fail_now;
    end
  end

  // ************************************************************
  // Events and interrupt
  // ************************************************************
  assign ev_set = {fail_now & ~fail_prev_q, tx_now & ~tx_prev_q, trip_now & ~trip_prev_q};

  // Sticky status: set beats a same-cycle write-one clear
  always @(posedge mclk_i) begin
    if (srst_i) begin
      ists_q <= {`POUC_EV_W{1'b0}};
      tx_prev_q <= 1'b0;
      trip_prev_q <= 1'b0;
      fail_prev_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      tx_prev_q <= tx_now;
      trip_prev_q <= trip_now;
      fail_prev_q <= fail_now;
      if (wr_acc && avs_address_i == `POUC_A_ISTS) begin
        ists_q <= (ists_q & ~avs_writedata_i[`POUC_EV_W-1:0]) | ev_set;
      end else begin
        ists_q <= ists_q | ev_set;
      end
      // Level output, one cycle behind status
      irq_o <= |(ists_q & imsk_q);
    end
  end

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************

  // Fixed one wait cycle per access keeps read data registered
  always @(posedge mclk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (!avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~bus_req;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (avs_address_i)
      `POUC_A_CTRL: begin
        rdata_d[`POUC_CTRL_W-1:0] = ctrl_q;
      end
      `POUC_A_CMIN: begin
        rdata_d[CMIN_W-1:0] = cmin_q;
      end
      `POUC_A_STAT: begin
        rdata_d[`POUC_STAT_W-1:0] = {win_open, carrier_equipment_fail_o, channel_transmit_o, scheme_trip_o};
      end
      `POUC_A_ISTS: begin
        rdata_d[`POUC_EV_W-1:0] = ists_q;
      end
      `POUC_A_IMSK: begin
        rdata_d[`POUC_EV_W-1:0] = imsk_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in the wait cycle, valid when waitrequest drops
  always @(posedge mclk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rdata_d;
    end
  end

  // Setting registers, written at the completing edge
  always @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_q <= `POUC_CTRL_RST;
      cmin_q <= `POUC_CMIN_RST;
      imsk_q <= {`POUC_EV_W{1'b0}};
    end else if (wr_acc) begin
      case (avs_address_i)
        `POUC_A_CTRL: begin
          ctrl_q <= avs_writedata_i[`POUC_CTRL_W-1:0];
        end
        `POUC_A_CMIN: begin
          cmin_q <= avs_writedata_i[CMIN_W-1:0];
        end
        `POUC_A_IMSK: begin
          imsk_q <= avs_writedata_i[`POUC_EV_W-1:0];
        end
        default: begin
          imsk_q <= imsk_q; // Read-only, write-one-clear or unmapped: ignored here
        end
      endcase
    end
  end

endmodule // pouc_top

//--- pouc_top_sva.sv
// Assertion checker watching the teleprotection block ports
module pouc_sva #(
  parameter int TICK_CYC = 4
) (
  // Clock and reset
  input wire mclk_i,
  input wire srst_i,
  // Register bus
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // Protection inputs and scheme outputs
  input wire underreach_pickup_i,
  input wire overreach_pickup_i,
  input wire reverse_current_block_i,
  input wire weak_infeed_echo_i,
  input wire weak_infeed_trip_i,
  input wire breaker_open_i,
  input wire channel_trip_block_in_i,
  input wire channel_receive_in_i,
  input wire guard_loss_in_i,
  input wire channel_transmit_o,
  input wire scheme_trip_o,
  input wire carrier_equipment_fail_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Two ticks of slack below 100 ms: the free-running tick may come early
  localparam int BRK_MIN = 98 * TICK_CYC;
  logic [31:0] brk_q; // Cycles the breaker has stayed open; wide enough for the full-rate tick
  // Counter saturates so long openings never wrap
  always @(posedge mclk_i) begin
    if (srst_i || !breaker_open_i) brk_q <= 32'h0000_0000;
    else if (brk_q != 32'hffff_ffff) brk_q <= brk_q + 32'h0000_0001;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest did not drop one cycle after a request");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest stayed low more than one cycle");
  a_rd_unmapped: assert property (avs_read_i && avs_waitrequest_o && avs_address_i > 3'h4 |=> avs_readdata_o == 32'h0)
    else $error("unmapped read returned nonzero");
  a_block_quiet: assert property (channel_trip_block_in_i |=> !scheme_trip_o && !channel_transmit_o)
    else $error("trip or transmit while blocked");
  a_trip_cause: assert property ($rose(scheme_trip_o) |->
    $past(overreach_pickup_i && !reverse_current_block_i || weak_infeed_trip_i))
    else $error("trip without an unmasked cause");
  a_tx_cause: assert property ($rose(channel_transmit_o) |-> $past(underreach_pickup_i ||
    overreach_pickup_i && !reverse_current_block_i || weak_infeed_echo_i || breaker_open_i))
    else $error("transmit without a cause");
  a_brk_delay: assert property ($rose(channel_transmit_o) && !$past(underreach_pickup_i ||
    overreach_pickup_i || weak_infeed_echo_i) |-> brk_q >= BRK_MIN)
    else $error("breaker transmit came too early");
  a_fail_cause: assert property ($rose(carrier_equipment_fail_o) |->
    $past(channel_receive_in_i && !guard_loss_in_i, 2))
    else $error("failure flag without reception alone");
  c_trip: cover property ($rose(scheme_trip_o));
  c_tx: cover property ($rose(channel_transmit_o));
  c_fail: cover property ($rose(carrier_equipment_fail_o));
endmodule // pouc_sva

//--- pouc_carrier.sv
// Carrier equipment model driving the guard-loss and reception contacts
module pouc_carrier #(
  parameter int SW_CYC = 8 // Guard to trip frequency switch time
) (
  input wire mclk_i,
  input wire [1:0] link_state_i, // 0 guard, 1 remote trip, 2 attenuated, 3 faulty
  input wire tx_i,
  output reg rx_o,
  output reg gl_o,
  output reg trip_freq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int sw_q; // Cycles spent switching toward trip frequency
  initial begin
    rx_o = 1'b0;
    gl_o = 1'b0;
    trip_freq_o = 1'b0;
    sw_q = 0;
  end
  // Guard drops at once, trip tone shows only after the switch time
  always @(posedge mclk_i) begin
    trip_freq_o <= tx_i;
    sw_q <= (link_state_i == 2'h1) ? sw_q + 1 : 0;
    gl_o <= (link_state_i == 2'h1) || (link_state_i == 2'h2);
    rx_o <= (link_state_i == 2'h3) || (link_state_i == 2'h1 && sw_q >= SW_CYC);
  end
endmodule // pouc_carrier

//--- permissive_overreach_unblock_logic_tb_top.sv
// Self-checking bench for the teleprotection logic
`include "pouc_map.vh"
module permissive_overreach_unblock_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4; // Short tick keeps the run brief
  logic mclk_i = 0, srst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [2:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic ur = 0, ov = 0, rcb = 0, echo = 0, wtrip = 0, brk = 0, blk = 0;
  logic [1:0] link = 0;
  wire rx, gl, tx, trip, fail, irq, waitreq, tfreq;
  wire [31:0] rdata;
  int n_mismatch = 0, tests_run = 0, cmin, s;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  initial forever #20 mclk_i = ~mclk_i;
  pouc_top #(.TICK_CYC(TK), .CMIN_W(16)) uut (.mclk_i(mclk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .underreach_pickup_i(ur), .overreach_pickup_i(ov), .reverse_current_block_i(rcb),
    .weak_infeed_echo_i(echo), .weak_infeed_trip_i(wtrip), .breaker_open_i(brk),
    .channel_trip_block_in_i(blk), .channel_receive_in_i(rx), .guard_loss_in_i(gl),
    .channel_transmit_o(tx), .scheme_trip_o(trip), .carrier_equipment_fail_o(fail), .irq_o(irq));
  pouc_carrier #(.SW_CYC(8)) u_car (.mclk_i(mclk_i), .link_state_i(link), .tx_i(tx),
    .rx_o(rx), .gl_o(gl), .trip_freq_o(tfreq));
  task give_verdict;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Bus cycle held until waitrequest is seen low
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      give_verdict;
    end else begin
      avs_write_i <= 0;
      avs_read_i <= 0;
    end
  endtask
  task rd(input logic [2:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task wms(input int m);
    repeat (m * TK) @(posedge mclk_i);
  endtask
  // Read data checked against the oldest note at the completing edge
  always @(posedge mclk_i) begin
    if (avs_read_i && waitreq === 1'b0) cmp32(rdata, exp_q.pop_front());
  end
  initial begin
    s = $urandom(63128);
    repeat (6) @(posedge mclk_i);
    srst_i <= 0;
    for (int a = 0; a < 6; a++) rd(a[2:0], 32'h0);
    wr_stat: bus(1'b1, `POUC_A_STAT, 32'hf);
    rd(`POUC_A_STAT, 32'h0);
    rd(3'h7, 32'h0);
    $display("test registers done");
    ov <= 1;
    link <= 1;
    wms(3);
    rd(`POUC_A_STAT, 32'h0);
    bus(1'b1, `POUC_A_CTRL, 32'h1);
    wms(2);
    rd(`POUC_A_STAT, 32'h3);
    cmp32({29'h0, fail, tx, trip}, 32'h3);
    rcb <= 1;
    wms(3);
    rd(`POUC_A_STAT, 32'h0);
    rcb <= 0;
    blk <= 1;
    wms(1);
    rd(`POUC_A_STAT, 32'h0);
    blk <= 0;
    ov <= 0;
    link <= 0;
    $display("test overreach done");
    cmin = 5 + $urandom % 10;
    bus(1'b1, `POUC_A_CMIN, cmin);
    bus(1'b1, `POUC_A_IMSK, 32'h2);
    ur <= 1;
    @(posedge mclk_i);
    ur <= 0;
    wms(cmin - 3);
    rd(`POUC_A_STAT, 32'h2);
    cmp32({31'h0, irq}, 32'h1);
    wms(4);
    rd(`POUC_A_STAT, 32'h0);
    bus(1'b1, `POUC_A_ISTS, 32'h2);
    repeat (2) @(posedge mclk_i);
    cmp32({31'h0, irq}, 32'h0);
    $display("test hold done");
    bus(1'b1, `POUC_A_CTRL, 32'h11);
    brk <= 1;
    wms(97);
    rd(`POUC_A_STAT, 32'h0);
    wms(4);
    rd(`POUC_A_STAT, 32'h2);
    brk <= 0;
    wms(cmin + 3);
    $display("test breaker done");
    bus(1'b1, `POUC_A_CTRL, 32'h0a);
    link <= 2;
    wms(12);
    rd(`POUC_A_STAT, 32'h8);
    ov <= 1;
    wms(1);
    rd(`POUC_A_STAT, 32'hb);
    ov <= 0;
    wms(150);
    rd(`POUC_A_STAT, 32'h0);
    link <= 1;
    ov <= 1;
    wms(3);
    rd(`POUC_A_STAT, 32'h3);
    cmp32({29'h0, fail, tx, trip}, 32'h3);
    cmp32({31'h0, tfreq}, 32'h1);
    ov <= 0;
    link <= 0;
    wms(cmin + 3);
    bus(1'b1, `POUC_A_CTRL, 32'h06);
    wtrip <= 1;
    rd(`POUC_A_STAT, 32'h0);
    bus(1'b1, `POUC_A_CTRL, 32'h0a);
    rd(`POUC_A_STAT, 32'h1);
    wtrip <= 0;
    echo <= 1;
    wms(1);
    rd(`POUC_A_STAT, 32'h2);
    echo <= 0;
    wms(cmin + 3);
    link <= 3;
    wms(195);
    rd(`POUC_A_STAT, 32'h0);
    wms(6);
    rd(`POUC_A_STAT, 32'h4);
    cmp32({29'h0, fail, tx, trip}, 32'h4);
    link <= 0;
    $display("test unblocking done");
    @(posedge mclk_i);
    cmp32(exp_q.size(), 32'h0);
    give_verdict;
  end
endmodule // permissive_overreach_unblock_logic_tb_top
bind pouc_top pouc_sva #(.TICK_CYC(TICK_CYC)) u_sva (.mclk_i(mclk_i), .srst_i(srst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .underreach_pickup_i(underreach_pickup_i), .overreach_pickup_i(overreach_pickup_i),
  .reverse_current_block_i(reverse_current_block_i), .weak_infeed_echo_i(weak_infeed_echo_i),
  .weak_infeed_trip_i(weak_infeed_trip_i), .breaker_open_i(breaker_open_i),
  .channel_trip_block_in_i(channel_trip_block_in_i), .channel_receive_in_i(channel_receive_in_i),
  .guard_loss_in_i(guard_loss_in_i), .channel_transmit_o(channel_transmit_o),
  .scheme_trip_o(scheme_trip_o), .carrier_equipment_fail_o(carrier_equipment_fail_o));
